// File: rtl/ccgow_pkg.sv
/*
  ccgow_pkg: constants, modes and carrier types for the cpu clock generator
  with oscillator watchdog. assumes a single 10 MHz system clock domain.
*/
package ccgow_pkg;

  // ************************************************************
  // register map (byte addresses, one aligned word each)
  // ************************************************************
  localparam logic [7:0] SYSCFG_OFS   = 8'h00;
  localparam logic [7:0] STATUS_OFS   = 8'h04;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h0C;

  // ************************************************************
  // field positions and reset values
  // ************************************************************
  localparam int          WDDIS_BIT      = 4;
  localparam logic [31:0] SYSCFG_RST     = 32'h0000_0000;
  localparam logic [31:0] IRQ_MASK_RST   = 32'h0000_0000;
  localparam int          WD_OVF_CYCLES  = 16;
  localparam logic [4:0]  WD_OVF_CNT     = 5'h10;
  localparam logic [2:0]  STRAP_RST      = 3'h7;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  // ************************************************************
  // strap codes
  // ************************************************************
  localparam logic [2:0] CODE_X4   = 3'h7;
  localparam logic [2:0] CODE_X3   = 3'h6;
  localparam logic [2:0] CODE_X2   = 3'h5;
  localparam logic [2:0] CODE_X5   = 3'h4;
  localparam logic [2:0] CODE_DIR  = 3'h3;
  localparam logic [2:0] CODE_X10  = 3'h2;
  localparam logic [2:0] CODE_PRE  = 3'h1;
  localparam logic [2:0] CODE_X2P5 = 3'h0;

  // clock source currently feeding the cpu
  typedef enum logic [1:0] {
    CCGOW_SRC_PLL  = 2'b00,
    CCGOW_SRC_DIR  = 2'b01,
    CCGOW_SRC_PRE  = 2'b10,
    CCGOW_SRC_FREE = 2'b11
  } ccgow_src_t;

  // status carrier
  typedef struct packed {
    logic       fail_latched;
    logic       pll_on;
    logic       pll_free;
    ccgow_src_t src;
    logic [2:0] straps;
    logic [4:0] factor_x2;
  } ccgow_stat_t;

endpackage : ccgow_pkg

// File: rtl/ccgow_top.sv
/*
  ccgow_top: cpu clock mode selection from straps, oscillator watchdog with
  latched switch-over, axi4-lite register slave and a masked interrupt.
  assumes osc_clock_input and pll_clock are level samples synchronous to clk;
  the actual analog clock mux sits outside and obeys the select outputs.
*/
// Overview of operation
// - straps caught on first edge after reset, held until next
// - strap code picks the multiplication factor
// - code 001 selects divide-by-two prescaler path
// - code 011 bypasses pll, direct input drive
// - other codes use pll, resync each factor-th
// - both cpu clock edges mark timing units
// - watchdog on after reset, disable bit 4
// - watchdog supervises direct and prescaled modes
// - counter counts pll clocks, clears on transition
// - sixteen pll clocks without transition means failure
// - failure switches to free clock, raises irq
// - switch-over sticks until hardware reset
// - watchdog off in bypass modes, no failure latched: external clock, pll powered down
`timescale 1ns/1ps
module ccgow_top (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // straps and clock samples
  input  wire logic [2:0]  clock_mode_strap_pins,
  input  wire logic        osc_clock_input,
  input  wire logic        pll_clock,
  // axi4-lite write address
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  // axi4-lite write data
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // axi4-lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // axi4-lite read address
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  // axi4-lite read data
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // clock control outputs
  output logic [1:0]       cpu_clk_sel,
  output logic [4:0]       pll_factor_x2,
  output logic             pll_enable,
  output logic             pll_free_run,
  output logic             cpu_phase_edge,
  output logic             osc_fail_irq
);

  // ************************************************************
  // strap capture
  // ************************************************************
  logic [2:0]  clock_mode_straps_ff;
  logic        strap_done_ff;

  // straps are taken on the first edge after release, then frozen
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clock_mode_straps_ff <= ccgow_pkg::STRAP_RST;
      strap_done_ff        <= 1'b0;
    end else if (!strap_done_ff) begin
      clock_mode_straps_ff <= clock_mode_strap_pins;
      strap_done_ff        <= 1'b1;
    end
  end

  // factor times two keeps 0.5 and 2.5 integral
  function automatic logic [4:0] factor_x2_of(input logic [2:0] code);
    case (code)
      ccgow_pkg::CODE_X4:   factor_x2_of = 5'h08;
      ccgow_pkg::CODE_X3:   factor_x2_of = 5'h06;
      ccgow_pkg::CODE_X2:   factor_x2_of = 5'h04;
      ccgow_pkg::CODE_X5:   factor_x2_of = 5'h0A;
      ccgow_pkg::CODE_DIR:  factor_x2_of = 5'h02;
      ccgow_pkg::CODE_X10:  factor_x2_of = 5'h14;
      ccgow_pkg::CODE_PRE:  factor_x2_of = 5'h01;
      default:              factor_x2_of = 5'h05;
    endcase
  endfunction : factor_x2_of

  // ************************************************************
  // registers
  // ************************************************************
  logic [31:0] syscfg_ff;
  logic [31:0] irq_stat_ff;
  logic [31:0] irq_mask_ff;
  logic        wd_dis;
  logic        bypass_mode;
  assign wd_dis      = syscfg_ff[ccgow_pkg::WDDIS_BIT];
  assign bypass_mode = (clock_mode_straps_ff == ccgow_pkg::CODE_DIR) ||
                       (clock_mode_straps_ff == ccgow_pkg::CODE_PRE);

  // ************************************************************
  // oscillator watchdog
  // ************************************************************
  logic       osc_prev_ff;
  logic       pll_prev_ff;
  logic [4:0] wd_cnt_ff;
  logic       fail_ff;
  logic       osc_edge;
  logic       pll_rise;
  logic       wd_active;
  assign osc_edge  = osc_clock_input != osc_prev_ff;
  assign pll_rise  = pll_clock && !pll_prev_ff;
  assign wd_active = !wd_dis && bypass_mode && strap_done_ff;

  // edge memories for input and pll samples
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_prev_ff <= 1'b0;
      pll_prev_ff <= 1'b0;
    end else begin
      osc_prev_ff <= osc_clock_input;
      pll_prev_ff <= pll_clock;
    end
  end

  // counter saturates at overflow so it cannot wrap and rearm
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wd_cnt_ff <= 5'h00;
    end else if (!wd_active || osc_edge) begin
      wd_cnt_ff <= 5'h00;
    end else if (pll_rise && wd_cnt_ff != ccgow_pkg::WD_OVF_CNT) begin
      wd_cnt_ff <= wd_cnt_ff + 5'h01;
    end
  end

  // failure latch cleared only by rst_n
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fail_ff <= 1'b0;
    end else if (wd_active && wd_cnt_ff == ccgow_pkg::WD_OVF_CNT) begin
      fail_ff <= 1'b1;
    end
  end

  // ************************************************************
  // clock source selection
  // ************************************************************
  ccgow_pkg::ccgow_src_t src_ff;
  ccgow_pkg::ccgow_src_t nxt_src;

  always_comb begin
    case (clock_mode_straps_ff)
      ccgow_pkg::CODE_DIR: nxt_src = ccgow_pkg::CCGOW_SRC_DIR;
      ccgow_pkg::CODE_PRE: nxt_src = ccgow_pkg::CCGOW_SRC_PRE;
      default:             nxt_src = ccgow_pkg::CCGOW_SRC_PLL;
    endcase
  end

  // switch waits for a pll edge to avoid a runt phase; once free, it stays
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      src_ff <= ccgow_pkg::CCGOW_SRC_PLL;
    end else if (fail_ff) begin
      if (pll_rise) begin
        src_ff <= ccgow_pkg::CCGOW_SRC_FREE;
      end
    end else begin
      src_ff <= nxt_src;
    end
  end

  // ************************************************************
  // outputs to clock mux and pll
  // ************************************************************
  logic [1:0] cpu_clk_sel_ff;
  logic [4:0] pll_factor_ff;
  logic       pll_enable_ff;
  logic       pll_free_ff;
  logic       edge_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_clk_sel_ff <= 2'b00;
      pll_factor_ff  <= 5'h08;
      pll_enable_ff  <= 1'b1;
      pll_free_ff    <= 1'b0;
      edge_ff        <= 1'b0;
    end else begin
      cpu_clk_sel_ff <= src_ff;
      pll_factor_ff  <= factor_x2_of(clock_mode_straps_ff);
      // pll off only in bypass with watchdog disabled
      pll_enable_ff  <= !(bypass_mode && wd_dis && !fail_ff);
      pll_free_ff    <= bypass_mode && (!wd_dis || fail_ff);
      // each edge of the selected cpu clock is one timing unit
      edge_ff        <= (src_ff == ccgow_pkg::CCGOW_SRC_DIR) ? osc_edge :
                        (src_ff == ccgow_pkg::CCGOW_SRC_PRE) ? (osc_edge && osc_clock_input) :
                        (pll_clock != pll_prev_ff);
    end
  end

  assign cpu_clk_sel    = cpu_clk_sel_ff;
  assign pll_factor_x2  = pll_factor_ff;
  assign pll_enable     = pll_enable_ff;
  assign pll_free_run   = pll_free_ff;
  assign cpu_phase_edge = edge_ff;

  // ************************************************************
  // axi4-lite slave
  // ************************************************************
  logic       aw_got_ff;
  logic       w_got_ff;
  logic [7:0] aw_addr_ff;
  logic [31:0] w_data_ff;
  logic [3:0] w_strb_ff;
  logic       bvalid_ff;
  logic [1:0] bresp_ff;
  logic       rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic       wr_fire;
  logic       rd_fire;
  ccgow_pkg::ccgow_stat_t stat;

  assign s_axi_awready = !aw_got_ff && !bvalid_ff;
  assign s_axi_wready  = !w_got_ff && !bvalid_ff;
  assign s_axi_arready = !rvalid_ff;
  assign wr_fire       = aw_got_ff && w_got_ff && !bvalid_ff;
  assign rd_fire       = s_axi_arvalid && s_axi_arready;

  assign stat.fail_latched = fail_ff;
  assign stat.pll_on       = pll_enable_ff;
  assign stat.pll_free     = pll_free_ff;
  assign stat.src          = src_ff;
  assign stat.straps       = clock_mode_straps_ff;
  assign stat.factor_x2    = pll_factor_ff;

  // write address and data may arrive in either order
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_got_ff  <= 1'b0;
      w_got_ff   <= 1'b0;
      aw_addr_ff <= 8'h00;
      w_data_ff  <= 32'h0000_0000;
      w_strb_ff  <= 4'h0;
    end else if (wr_fire) begin
      aw_got_ff <= 1'b0;
      w_got_ff  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_ff  <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_ff  <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end
    end
  end

  // config and mask registers, low byte lane only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      syscfg_ff   <= ccgow_pkg::SYSCFG_RST;
      irq_mask_ff <= ccgow_pkg::IRQ_MASK_RST;
    end else if (wr_fire && w_strb_ff[0]) begin
      if (aw_addr_ff == ccgow_pkg::SYSCFG_OFS) begin
        syscfg_ff <= {27'h000_0000, w_data_ff[ccgow_pkg::WDDIS_BIT], 4'h0};
      end
      if (aw_addr_ff == ccgow_pkg::IRQ_MASK_OFS) begin
        irq_mask_ff <= {31'h0000_0000, w_data_ff[0]};
      end
    end
  end

  // write response
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= ccgow_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= (aw_addr_ff == ccgow_pkg::SYSCFG_OFS || aw_addr_ff == ccgow_pkg::IRQ_MASK_OFS ||
                    aw_addr_ff == ccgow_pkg::STATUS_OFS || aw_addr_ff == ccgow_pkg::IRQ_STAT_OFS)
                   ? ccgow_pkg::RESP_OKAY : ccgow_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // read data mux
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= ccgow_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_ff <= 1'b1;
      rresp_ff  <= ccgow_pkg::RESP_OKAY;
      case (s_axi_araddr)
        ccgow_pkg::SYSCFG_OFS:   rdata_ff <= syscfg_ff;
        ccgow_pkg::STATUS_OFS:   rdata_ff <= {19'h0_0000, stat};
        ccgow_pkg::IRQ_STAT_OFS: rdata_ff <= irq_stat_ff;
        ccgow_pkg::IRQ_MASK_OFS: rdata_ff <= irq_mask_ff;
        default: begin
          rdata_ff <= 32'h0000_0000;
          rresp_ff <= ccgow_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp  = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata  = rdata_ff;
  assign s_axi_rresp  = rresp_ff;

  // ************************************************************
  // interrupt
  // ************************************************************
  logic fail_prev_ff;
  logic fail_event;
  assign fail_event = fail_ff && !fail_prev_ff;

  // set beats read-clear in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fail_prev_ff <= 1'b0;
      irq_stat_ff  <= 32'h0000_0000;
    end else begin
      fail_prev_ff <= fail_ff;
      if (fail_event) begin
        irq_stat_ff[0] <= 1'b1;
      end else if (rd_fire && s_axi_araddr == ccgow_pkg::IRQ_STAT_OFS) begin
        irq_stat_ff[0] <= 1'b0;
      end
    end
  end

  assign osc_fail_irq = |(irq_stat_ff & irq_mask_ff);

  // ************************************************************
  // checks
  // ************************************************************
  a_straps_frozen: assert property (@(posedge clk) disable iff (!rst_n)
    $past(strap_done_ff) |-> $stable(clock_mode_straps_ff))
    else $error("straps changed after capture");
  a_factor_map: assert property (@(posedge clk) disable iff (!rst_n)
    strap_done_ff && clock_mode_straps_ff == ccgow_pkg::CODE_X10 |=> pll_factor_x2 == 5'h14)
    else $error("wrong factor for x10");
  a_prescale_sel: assert property (@(posedge clk) disable iff (!rst_n)
    !fail_ff && clock_mode_straps_ff == ccgow_pkg::CODE_PRE |=> ##1 cpu_clk_sel == 2'b10)
    else $error("prescaler not selected");
  a_direct_sel: assert property (@(posedge clk) disable iff (!rst_n)
    !fail_ff && clock_mode_straps_ff == ccgow_pkg::CODE_DIR |=> ##1 cpu_clk_sel == 2'b01)
    else $error("direct drive not selected");
  a_pll_mode_on: assert property (@(posedge clk) disable iff (!rst_n)
    !bypass_mode |=> pll_enable && cpu_clk_sel == 2'b00)
    else $error("pll mode not driving cpu");
  a_edge_direct: assert property (@(posedge clk) disable iff (!rst_n)
    src_ff == ccgow_pkg::CCGOW_SRC_DIR && osc_edge |=> cpu_phase_edge)
    else $error("direct edge missed");
  a_wd_disabled: assert property (@(posedge clk) disable iff (!rst_n)
    wd_dis |=> wd_cnt_ff == 5'h00)
    else $error("watchdog counts while disabled");
  a_wd_clear: assert property (@(posedge clk) disable iff (!rst_n)
    osc_edge |=> wd_cnt_ff == 5'h00)
    else $error("counter not cleared on edge");
  a_wd_overflow: assert property (@(posedge clk) disable iff (!rst_n)
    wd_active && wd_cnt_ff == ccgow_pkg::WD_OVF_CNT |=> fail_ff)
    else $error("overflow not flagged");
  a_fail_switch: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(fail_ff) |-> ##[1:40] cpu_clk_sel == 2'b11 && irq_stat_ff[0])
    else $error("failure switch-over missing");
  a_fail_sticky: assert property (@(posedge clk) disable iff (!rst_n)
    fail_ff |=> fail_ff)
    else $error("failure latch released");
  a_pll_off: assert property (@(posedge clk) disable iff (!rst_n)
    bypass_mode && wd_dis && !fail_ff |=> !pll_enable)
    else $error("pll left on with watchdog disabled");
  a_clean_switch: assert property (@(posedge clk) disable iff (!rst_n)
    src_ff == ccgow_pkg::CCGOW_SRC_FREE && $past(src_ff) != ccgow_pkg::CCGOW_SRC_FREE
    |-> $past(pll_rise))
    else $error("switch not at pll edge");

endmodule : ccgow_top

// File: test/ccgow_osc_model.sv
/*
  ccgow_osc_model: external crystal plus the pll free-running oscillator,
  given as level samples on the system clock.
  assumes the bench changes run and half_cyc just after a rising edge.
*/
`timescale 1ns/1ps
module ccgow_osc_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // bench control
  input  wire logic       run,
  input  wire logic [3:0] half_cyc,
  // clock samples
  output logic            osc_clock_input,
  output logic            pll_clock
);
  logic [3:0] cnt_ff;

  // crystal toggles every half_cyc cycles; a dead one freezes its level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff          <= 4'h0;
      osc_clock_input <= 1'b0;
    end else if (run) begin
      cnt_ff <= (cnt_ff + 4'h1 >= half_cyc) ? 4'h0 : cnt_ff + 4'h1;
      if (cnt_ff + 4'h1 >= half_cyc) begin
        osc_clock_input <= ~osc_clock_input;
      end
    end
  end

  // pll free-running clock never stops, rises every second cycle
  always_ff @(posedge clk) begin
    pll_clock <= (pll_clock === 1'b1) ? 1'b0 : 1'b1;
  end
endmodule : ccgow_osc_model

// File: test/tb_top.sv
/*
  tb_top: self-checking bench for the cpu clock generator and watchdog.
  assumes a 10 MHz clk, the oscillator model and axi4-lite register access.
*/
`timescale 1ns/1ps
module tb_top;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [2:0]  clock_mode_strap_pins = 3'h7;
  logic        osc_clock_input, pll_clock, run = 1'b1;
  logic        s_axi_awvalid = 1'b0, s_axi_awready, s_axi_wvalid = 1'b0, s_axi_wready;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_bvalid, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready = 1'b0;
  logic [1:0]  s_axi_bresp, s_axi_rresp, cpu_clk_sel;
  logic [4:0]  pll_factor_x2;
  logic        pll_enable, pll_free_run, cpu_phase_edge, osc_fail_irq;
  int          fails = 0;
  int          checks_done = 0;
  // expected factor times two, indexed by strap code
  logic [4:0]  fx2_tab [8] = '{5'h05, 5'h01, 5'h14, 5'h02, 5'h0a, 5'h04, 5'h06, 5'h08};

  always #50 clk = ~clk;

  ccgow_top DUT (.clk, .rst_n, .clock_mode_strap_pins, .osc_clock_input, .pll_clock,
    .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp, .cpu_clk_sel, .pll_factor_x2, .pll_enable,
    .pll_free_run, .cpu_phase_edge, .osc_fail_irq);

  ccgow_osc_model osc (.clk, .rst_n, .run, .half_cyc(4'h3), .osc_clock_input, .pll_clock);

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // one edge first so no strobe is assigned twice in one time step
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 200);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    chk("write answer", 32'h0, 32'(n >= 200));
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 200);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    chk("read answer", 32'h0, 32'(n >= 200));
  endtask : axi_rd

  // reset with a strap code, then move the straps away from it
  task automatic do_reset(input logic [2:0] code);
    @(posedge clk);
    rst_n                 <= 1'b0;
    clock_mode_strap_pins <= code;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    clock_mode_strap_pins <= ~code;
    repeat (3) @(posedge clk);
  endtask : do_reset

  function automatic logic [1:0] src_of(input logic [2:0] code);
    return (code == 3'h3) ? 2'h1 : (code == 3'h1) ? 2'h2 : 2'h0;
  endfunction : src_of

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_straps;
    logic [31:0] d;
    logic [1:0]  r;
    for (int i = 0; i < 8; i++) begin
      do_reset(3'(i));
      axi_rd(ccgow_pkg::STATUS_OFS, d, r);
      chk("factor", 32'(fx2_tab[i]), 32'(pll_factor_x2));
      chk("clock select", 32'(src_of(3'(i))), 32'(cpu_clk_sel));
      chk("pll free run", 32'(i == 1 || i == 3), 32'(pll_free_run));
      chk("pll on", 32'h1, 32'(pll_enable));
      chk("status", 32'({src_of(3'(i)), 3'(i), fx2_tab[i]}), 32'(d[9:0]));
    end
  endtask : t_straps

  task automatic t_fail(input logic [2:0] code, input int div);
    logic [31:0] d;
    logic [1:0]  r;
    logic        prev;
    int          tr, pe, n;
    tr = 0;
    pe = 0;
    do_reset(code);
    repeat (40) @(posedge clk);
    prev = osc_clock_input;
    // cpu edges against input transitions, both edges count
    repeat (60) begin
      @(posedge clk);
      if (osc_clock_input !== prev) tr++;
      prev = osc_clock_input;
      if (cpu_phase_edge === 1'b1) pe++;
    end
    chk("phase edges", 32'h1, 32'(pe * div >= tr - div && pe * div <= tr + div));
    chk("select before fail", 32'(src_of(code)), 32'(cpu_clk_sel));
    run <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (cpu_clk_sel !== 2'h3 && n < 80);
    chk("fail not early", 32'h1, 32'(n >= 30 && n < 80));
    chk("irq masked", 32'h0, 32'(osc_fail_irq));
    axi_wr(ccgow_pkg::IRQ_MASK_OFS, 32'h0000_0001, r);
    repeat (2) @(posedge clk);
    chk("irq raised", 32'h1, 32'(osc_fail_irq));
    axi_rd(ccgow_pkg::IRQ_STAT_OFS, d, r);
    chk("irq status", 32'h1, 32'(d[0]));
    repeat (2) @(posedge clk);
    chk("irq cleared", 32'h0, 32'(osc_fail_irq));
    run <= 1'b1;
    repeat (60) @(posedge clk);
    chk("select sticks", 32'h3, 32'(cpu_clk_sel));
    do_reset(code);
    chk("select restored", 32'(src_of(code)), 32'(cpu_clk_sel));
  endtask : t_fail

  task automatic t_disable;
    logic [31:0] d;
    logic [1:0]  r;
    do_reset(3'h3);
    axi_wr(ccgow_pkg::SYSCFG_OFS, 32'h1 << ccgow_pkg::WDDIS_BIT, r);
    chk("disable resp", 32'(ccgow_pkg::RESP_OKAY), 32'(r));
    axi_rd(ccgow_pkg::SYSCFG_OFS, d, r);
    chk("disable bit", 32'h0000_0010, d);
    chk("pll off", 32'h0, 32'(pll_enable));
    run <= 1'b0;
    repeat (80) @(posedge clk);
    chk("still external", 32'h1, 32'(cpu_clk_sel));
    axi_rd(ccgow_pkg::IRQ_STAT_OFS, d, r);
    chk("no fail flag", 32'h0, 32'(d[0]));
    run <= 1'b1;
  endtask : t_disable

  task automatic t_unmapped;
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(8'h10, d, r);
    chk("unmapped read resp", 32'(ccgow_pkg::RESP_SLVERR), 32'(r));
    chk("unmapped read data", 32'h0000_0000, d);
    axi_wr(8'h14, 32'hffff_ffff, r);
    chk("unmapped write resp", 32'(ccgow_pkg::RESP_SLVERR), 32'(r));
  endtask : t_unmapped

  // ************************************************************
  // run control
  // ************************************************************
  task automatic final_report;
    if (fails == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report

  // hang guard well beyond the less than a thousand cycles the tests need
  initial begin
    #2_000_000;
    fails++;
    final_report();
  end

  initial begin
    t_straps();
    t_fail(3'h3, 1);
    t_fail(3'h1, 2);
    t_disable();
    t_unmapped();
    final_report();
  end
endmodule : tb_top
